// ==== rtl/fdo_pkg.sv ====
package fdo_pkg;
   // APB byte offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_MASK       = 8'h04;
   localparam logic [7:0]  OFS_STATUS     = 8'h08;
   localparam logic [7:0]  OFS_CLEAR      = 8'h0C;
   // Status word bit positions
   localparam int          ST_COMMON_FLAG = 15;
   localparam int          ST_POR         = 14;
   localparam int          ST_SER_ERR     = 13;
   localparam int          ST_OVERTEMP    = 12;
   localparam int          NUM_MASKABLE   = 10;
   // Serial frame fields
   localparam int          FR_ADDR_HI     = 15;
   localparam int          FR_ADDR_LO     = 12;
   localparam int          FR_WRITE       = 11;
   localparam int          FR_DATA_HI     = 10;
   localparam int          FR_DATA_LO     = 1;
   localparam logic [3:0]  SADDR_CFG      = 4'h0;
   localparam logic [3:0]  SADDR_MASK     = 4'h1;
   localparam logic [4:0]  FRAME_EDGES    = 5'h10;
   localparam logic [4:0]  EDGE_SAT       = 5'h11;
   // Values after reset
   localparam logic [1:0]  SEL_RESET      = 2'h0;
   localparam logic [9:0]  MASK_RESET     = 10'h000;
   // Diagnostic pin sources
   typedef enum logic [1:0] {
      SEL_FLAG   = 2'h0,
      SEL_PULSED = 2'h1,
      SEL_TEMP   = 2'h2,
      SEL_OFFSET = 2'h3
   } fdo_diag_sel_t;
   // Pulsed flag timing
   localparam int          SYS_CLK_KHZ      = 40000;
   localparam int          PULSE_PERIOD_MS  = 100;
   localparam int          DUTY_FAULT_PCT   = 20;
   localparam int          DUTY_OK_PCT      = 80;
   localparam int          PULSE_PERIOD_CYC = SYS_CLK_KHZ * PULSE_PERIOD_MS;
   localparam int          PULSE_CNT_W      = 22;
endpackage

// ==== rtl/fdo_core_if.sv ====
`timescale 1ns/1ps
interface fdo_core_if;
   logic [15:0] frame;
   logic [4:0]  edgeCnt;
   logic [15:0] snap;
   logic        sdoBit;
   logic        faultNow;
   logic        pulseOut;
   modport link  (output frame, edgeCnt, sdoBit, input snap);
   modport pulse (input faultNow, output pulseOut);
   modport core  (input frame, edgeCnt, sdoBit, pulseOut, output snap, faultNow);
endinterface

// ==== rtl/fdo_serial_link.sv ====
`timescale 1ns/1ps
module fdo_serial_link (
   input  wire logic serialClk,
   input  wire logic serialStrobeN,
   input  wire logic serialDataIn,
   fdo_core_if.link  bus
);
   typedef struct packed {
      logic [15:0] sh;
      logic [4:0]  cnt;
   } fdo_link_st_t;

   fdo_link_st_t q;
   fdo_link_st_t n;
   logic [3:0]   bitIdx;
   logic [15:0]  frameHeld_q;
   logic [4:0]   cntHeld_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Shift in, count rising edges, saturate above a full frame
   always_comb begin
      n = q;
      n.sh = {q.sh[14:0], serialDataIn};
      if (q.cnt != fdo_pkg::EDGE_SAT) begin
         n.cnt = 5'(q.cnt + 5'h01);
      end
      bitIdx = 4'hF - q.cnt[3:0];
   end

   // Strobe high ends the frame and clears the link state
   always_ff @(posedge serialClk or posedge serialStrobeN) begin
      if (serialStrobeN) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // Frame kept at strobe rise, the strobe high clears the live state at once
   // Core reads it only after its synchronised strobe rise, so it stands still
   always_ff @(posedge serialStrobeN) begin
      frameHeld_q <= q.sh;
      cntHeld_q   <= q.cnt;
   end

   // Status snapshot leaves msb first, flag before any edge
   assign bus.sdoBit  = q.cnt[4] ? 1'b0 : bus.snap[bitIdx];
   assign bus.frame   = frameHeld_q;
   assign bus.edgeCnt = cntHeld_q;

   ////////////////////////////////////////////////////////////////////////////////
   sdoFlag_a : assert property (@(posedge serialClk) disable iff (serialStrobeN)
      (q.cnt == 5'h00) |-> (bus.sdoBit == bus.snap[fdo_pkg::ST_COMMON_FLAG]))
      else $error("common flag not first on serial output");
   sdoShift_a : assert property (@(posedge serialClk) disable iff (serialStrobeN)
      (q.cnt == 5'h02) |=> (bus.sdoBit == bus.snap[12]))
      else $error("status word not shifted in order");
endmodule

// ==== rtl/fdo_diag_pulse.sv ====
`timescale 1ns/1ps
module fdo_diag_pulse #(
   parameter int PERIOD_CYC = fdo_pkg::PULSE_PERIOD_CYC
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   fdo_core_if.pulse bus
);
   localparam int HI_FAULT_I = PERIOD_CYC * fdo_pkg::DUTY_FAULT_PCT / 100;
   localparam int HI_OK_I    = PERIOD_CYC * fdo_pkg::DUTY_OK_PCT / 100;
   localparam logic [fdo_pkg::PULSE_CNT_W-1:0] LAST     = fdo_pkg::PULSE_CNT_W'(PERIOD_CYC - 1);
   localparam logic [fdo_pkg::PULSE_CNT_W-1:0] HI_FAULT = fdo_pkg::PULSE_CNT_W'(HI_FAULT_I);
   localparam logic [fdo_pkg::PULSE_CNT_W-1:0] HI_OK    = fdo_pkg::PULSE_CNT_W'(HI_OK_I);

   typedef struct packed {
      logic [fdo_pkg::PULSE_CNT_W-1:0] cnt;
      logic                            out;
   } fdo_pulse_st_t;

   fdo_pulse_st_t q;
   fdo_pulse_st_t n;

   ////////////////////////////////////////////////////////////////////////////////
   // Free running period counter, high phase picked by fault state
   always_comb begin
      n = q;
      n.cnt = (q.cnt == LAST) ? '0 : q.cnt + 1'b1;
      n.out = q.cnt < (bus.faultNow ? HI_FAULT : HI_OK);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.pulseOut = q.out;

   ////////////////////////////////////////////////////////////////////////////////
   pulseWrap_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.cnt == LAST) |=> (q.cnt == '0))
      else $error("pulse period did not wrap");
   dutyFault_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (bus.faultNow && q.cnt >= HI_FAULT) |=> !bus.pulseOut)
      else $error("fault duty too long");
   dutyOk_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!bus.faultNow && q.cnt < HI_OK) |=> bus.pulseOut)
      else $error("no-fault duty too short");
endmodule

// ==== rtl/fdo_fault_report.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Every fault except power-on, serial error, overtemperature and latched shutdown has its own mask bit.
// - A two-bit select picks flag or pulsed flag for the pin; the temperature and offset codes hold it high.
// - After reset the pin shows the general flag, low while a fault is present.
// - In flag mode the pin is low while an unmasked fault input, overtemperature or latched shutdown is present, else high.
// - In pulsed mode the pin repeats a 100 ms period, 20% high on fault, 80% otherwise.
// - The status word can be read at any time regardless of bridge state.
// - Every serial write shifts the status word out during the same transfer.
// - Status bit 15 is high whenever any fault bit of the status word is set.
// - The common flag is on the serial output as soon as the strobe falls.
// - Fault bits latch and stay set until a fault register reset.
// - A frame without exactly 16 edges or with even parity is dropped and flags an error.
module fdo_fault_report #(
   parameter int PULSE_PERIOD_CYC = fdo_pkg::PULSE_PERIOD_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serialClk,
   input  wire logic        serialStrobeN,
   input  wire logic        serialDataIn,
   output logic             serialDataOut,
   input  wire logic [9:0]  faultIn,
   input  wire logic        overtempFaultIn,
   input  wire logic        latchedOffIn,
   output logic             diagPin,
   output logic      [1:0]  diagMode
);
   typedef struct packed {
      logic [1:0]  diagSel;
      logic [9:0]  mask;
      logic        por;
      logic        serErr;
      logic        overtemp;
      logic [9:0]  flt;
      logic [11:0] inS1;
      logic [11:0] inS2;
      logic [2:0]  stbS;
      logic [15:0] snap;
      logic        diagPin;
      logic [1:0]  diagMode;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } fdo_top_st_t;

   localparam fdo_top_st_t RESET_ST = '{
      diagSel: fdo_pkg::SEL_RESET, mask: fdo_pkg::MASK_RESET, por: 1'b1,
      stbS: 3'h7, diagPin: 1'b1, default: '0};

   fdo_top_st_t q;
   fdo_top_st_t n;
   fdo_core_if  bus ();
   logic        present;
   logic        frameEnd;
   logic        frameOk;
   logic        serWr;
   logic        apbWr;
   logic        apbClr;
   logic        clrAll;
   logic [9:0]  setMask;

   // Status word with common flag on top
   function automatic logic [15:0] statusWord(input fdo_top_st_t s);
      logic [14:0] low;
      low = {s.por, s.serErr, s.overtemp, 2'h0, s.flt};
      return {|low, low};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   fdo_serial_link u_link (
      .serialClk     (serialClk),
      .serialStrobeN (serialStrobeN),
      .serialDataIn  (serialDataIn),
      .bus           (bus.link)
   );

   fdo_diag_pulse #(.PERIOD_CYC(PULSE_PERIOD_CYC)) u_pulse (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .bus     (bus.pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = q;
      // Pin inputs through two flops
      n.inS1 = {latchedOffIn, overtempFaultIn, faultIn};
      n.inS2 = q.inS1;
      n.stbS = {q.stbS[1:0], serialStrobeN};
      // Frame check at strobe rise, link state is idle then
      frameEnd = q.stbS[1] & ~q.stbS[2];
      frameOk  = (bus.edgeCnt == fdo_pkg::FRAME_EDGES) && (^bus.frame);
      serWr    = frameEnd & frameOk & bus.frame[fdo_pkg::FR_WRITE];
      // APB write, taken when pready is seen
      apbWr  = psel & penable & q.pready & pwrite & ~q.pslverr;
      apbClr = apbWr && (paddr == fdo_pkg::OFS_CLEAR);
      clrAll = serWr | apbClr;
      // Present condition, maskable faults gated
      setMask = q.inS2[9:0] & ~q.mask;
      present = (|setMask) | q.inS2[10] | q.inS2[11];
      // Sticky fault bits, set beats clear
      n.flt      = (clrAll ? 10'h000 : q.flt) | setMask;
      n.overtemp = (~clrAll & q.overtemp) | q.inS2[10];
      n.por      = ~clrAll & q.por;
      n.serErr   = (~clrAll & q.serErr) | (frameEnd & ~frameOk);
      // Register writes from APB
      if (apbWr && paddr == fdo_pkg::OFS_CTRL) begin
         n.diagSel = pwdata[1:0];
      end else if (apbWr && paddr == fdo_pkg::OFS_MASK) begin
         n.mask = pwdata[9:0];
      end
      // Serial writes, dropped on a bad frame
      if (serWr && bus.frame[15:12] == fdo_pkg::SADDR_CFG) begin
         n.diagSel = bus.frame[2:1];
      end else if (serWr && bus.frame[15:12] == fdo_pkg::SADDR_MASK) begin
         n.mask = bus.frame[fdo_pkg::FR_DATA_HI:fdo_pkg::FR_DATA_LO];
      end
      // Snapshot refreshed between frames
      if (q.stbS[1]) begin
         n.snap = statusWord(q);
      end
      // Diagnostic pin source
      n.diagMode = q.diagSel;
      case (q.diagSel)
         fdo_pkg::SEL_FLAG: begin
            n.diagPin = ~present;
         end
         fdo_pkg::SEL_PULSED: begin
            n.diagPin = bus.pulseOut;
         end
         default: begin
            n.diagPin = 1'b1;
         end
      endcase
      // APB read, answered in the access phase
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         if (paddr == fdo_pkg::OFS_CTRL) begin
            n.prdata[1:0] = q.diagSel;
         end else if (paddr == fdo_pkg::OFS_MASK) begin
            n.prdata[9:0] = q.mask;
         end else if (paddr == fdo_pkg::OFS_STATUS) begin
            n.prdata[15:0] = statusWord(q);
         end else if (paddr != fdo_pkg::OFS_CLEAR) begin
            n.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= RESET_ST;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs and link side values
   assign bus.snap      = q.snap;
   assign bus.faultNow  = present;
   assign serialDataOut = bus.sdoBit;
   assign prdata        = q.prdata;
   assign pready        = q.pready;
   assign pslverr       = q.pslverr;
   assign diagPin       = q.diagPin;
   assign diagMode      = q.diagMode;

   ////////////////////////////////////////////////////////////////////////////////
   maskGate_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.mask[3] && !q.flt[3]) |=> !q.flt[3])
      else $error("masked fault bit was set");
   latchHold_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.flt[3] && !clrAll) |=> q.flt[3])
      else $error("fault bit dropped without reset");
   commonFlag_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.stbS[1] && (|q.flt)) |=> q.snap[fdo_pkg::ST_COMMON_FLAG])
      else $error("common flag missing with fault set");
   serErr_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (frameEnd && bus.edgeCnt != fdo_pkg::FRAME_EDGES) |=> (q.serErr && $stable(q.diagSel)))
      else $error("bad frame not flagged or not dropped");
   flagMode_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.diagSel == fdo_pkg::SEL_FLAG) |=> (q.diagPin == !$past(present)))
      else $error("flag pin does not follow fault");
   pulseMode_a : assert property (@(posedge sys_clk) disable iff (!arst_n)
      (q.diagSel == fdo_pkg::SEL_PULSED) |=> (q.diagPin == $past(bus.pulseOut)))
      else $error("pulsed pin does not follow pulse");
endmodule

// ==== testbench/fdo_host_model.sv ====
`timescale 1ns/1ps
module fdo_host_model (
   output logic      serialClk,
   output logic      serialStrobeN,
   output logic      serialDataIn,
   input  wire logic serialDataOut
);
   logic [15:0] rxWord;
   logic        flagBit;
   // Idle link: clock parked low, strobe high
   initial begin
      serialClk     = 1'b0;
      serialStrobeN = 1'b1;
      serialDataIn  = 1'b0;
   end
   // One frame, msb first, 6 ns bit clock only inside the frame
   task automatic frame(input logic [15:0] txWord, input int edgeCount);
      serialStrobeN = 1'b0;
      #3;
      flagBit = serialDataOut;
      for (int k = 0; k < edgeCount; k++) begin
         serialDataIn = (k < 16) ? txWord[15 - k] : 1'b0;
         #3;
         if (k < 16) rxWord[15 - k] = serialDataOut;
         serialClk = 1'b1;
         #3;
         serialClk = 1'b0;
      end
      #3;
      serialStrobeN = 1'b1;
      serialDataIn  = ~serialDataIn; // Released line shows no stale value
   endtask
endmodule

// ==== testbench/test_fault_reporting_diag_output.sv ====
`timescale 1ns/1ps
module test_fault_reporting_diag_output;
   logic        sys_clk;
   logic        arst_n;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serialClk;
   logic        serialStrobeN;
   logic        serialDataIn;
   logic        serialDataOut;
   logic [9:0]  faultIn;
   logic        overtempFaultIn;
   logic        latchedOffIn;
   logic        diagPin;
   logic [1:0]  diagMode;
   logic [31:0] rd;
   logic        err;
   int          bad_count;
   int          check_count;

   ////////////////////////////////////////////////////////////////////////////////
   fdo_fault_report #(.PULSE_PERIOD_CYC(100)) u_fdo_fault_report (
      .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialClk(serialClk), .serialStrobeN(serialStrobeN), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut), .faultIn(faultIn), .overtempFaultIn(overtempFaultIn),
      .latchedOffIn(latchedOffIn), .diagPin(diagPin), .diagMode(diagMode));
   fdo_host_model u_fdo_host_model (
      .serialClk(serialClk), .serialStrobeN(serialStrobeN), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut));

   // System clock, 25 ns
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, bounded wait on pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         bad_count++;
         stop_test();
      end
      @(negedge sys_clk);
   endtask
   // Read and compare
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   // Bounded wait for a pin level
   task automatic wait_pin(input logic v);
      for (int i = 0; i < 12 && diagPin !== v; i++) @(negedge sys_clk);
      chk("diagPin", {31'h0, v}, {31'h0, diagPin});
   endtask
   // High cycles over one pulse period
   task automatic duty(input int exp);
      int n;
      n = 0;
      repeat (200) @(negedge sys_clk);
      repeat (100) begin
         @(negedge sys_clk);
         if (diagPin === 1'b1) n++;
      end
      chk("pulse high count", exp, n);
   endtask
   // Serial frame with odd parity unless spoiled
   task automatic sframe(input logic [3:0] a, input logic [9:0] d, input int n, input logic bad);
      logic [15:0] w;
      w[15:1] = {a, 1'b1, d};
      w[0] = ~^w[15:1] ^ bad;
      u_fdo_host_model.frame(w, n);
      repeat (8) @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_reset();
      chk("diagPin", 1, diagPin);
      chk("diagMode", 0, diagMode);
      rdchk(fdo_pkg::OFS_STATUS, 32'hC000, "status after reset");
   endtask
   task automatic test_flag();
      apb(1'b1, fdo_pkg::OFS_CLEAR, 32'h0);
      rdchk(fdo_pkg::OFS_STATUS, 32'h0, "status cleared");
      rdchk(8'h10, 32'h0, "unmapped read");
      chk("pslverr", 1, err);
      @(posedge sys_clk) faultIn[3] <= 1'b1;
      wait_pin(1'b0);
      rdchk(fdo_pkg::OFS_STATUS, 32'h8008, "fault latched");
      @(posedge sys_clk) faultIn <= 10'h000;
      wait_pin(1'b1);
      rdchk(fdo_pkg::OFS_STATUS, 32'h8008, "fault held");
      @(posedge sys_clk) latchedOffIn <= 1'b1;
      wait_pin(1'b0);
      @(posedge sys_clk) latchedOffIn <= 1'b0;
      wait_pin(1'b1);
   endtask
   task automatic test_mask();
      apb(1'b1, fdo_pkg::OFS_MASK, 32'h8);
      rdchk(fdo_pkg::OFS_MASK, 32'h8, "mask readback");
      apb(1'b1, fdo_pkg::OFS_CLEAR, 32'h0);
      @(posedge sys_clk);
      faultIn[3] <= 1'b1;
      overtempFaultIn <= 1'b1;
      repeat (8) @(negedge sys_clk);
      rdchk(fdo_pkg::OFS_STATUS, 32'h9000, "masked fault and overtemperature");
      @(posedge sys_clk);
      faultIn <= 10'h000;
      overtempFaultIn <= 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic test_serial();
      sframe(fdo_pkg::SADDR_MASK, 10'h000, 16, 1'b0);
      chk("first bit", 1, u_fdo_host_model.flagBit);
      chk("shifted status", 32'h9000, u_fdo_host_model.rxWord);
      rdchk(fdo_pkg::OFS_MASK, 32'h0, "serial mask write");
      rdchk(fdo_pkg::OFS_STATUS, 32'h0, "status after write");
      sframe(fdo_pkg::SADDR_MASK, 10'h3FF, 15, 1'b0);
      rdchk(fdo_pkg::OFS_STATUS, 32'hA000, "short frame");
      sframe(fdo_pkg::SADDR_MASK, 10'h3FF, 16, 1'b1);
      chk("first bit after error", 1, u_fdo_host_model.flagBit);
      sframe(fdo_pkg::SADDR_MASK, 10'h3FF, 17, 1'b0);
      rdchk(fdo_pkg::OFS_MASK, 32'h0, "refused frames");
   endtask
   task automatic test_pulse();
      apb(1'b1, fdo_pkg::OFS_CLEAR, 32'h0);
      sframe(fdo_pkg::SADDR_CFG, 10'h001, 16, 1'b0);
      chk("diagMode serial", 1, diagMode);
      duty(80);
      @(posedge sys_clk) latchedOffIn <= 1'b1;
      duty(20);
      @(posedge sys_clk) latchedOffIn <= 1'b0;
      for (int m = 3; m >= 0; m--) begin
         apb(1'b1, fdo_pkg::OFS_CTRL, m);
         // Mode copy follows the select one edge after the write
         @(negedge sys_clk);
         chk("diagMode", m, diagMode);
         if (m != 1) wait_pin(1'b1);
      end
   endtask

   // Reset, then the scenarios
   initial begin
      bad_count = 0;
      check_count = 0;
      arst_n = 1'b0;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
      faultIn = 10'h000;
      overtempFaultIn = 1'b0;
      latchedOffIn = 1'b0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (4) @(negedge sys_clk);
      test_reset();
      test_flag();
      test_mask();
      test_serial();
      test_pulse();
      stop_test();
   end
endmodule
